/* File: design/erx_decode.sv */
// instruction pattern decoder
`timescale 1ns/1ns
module erx_decode (
    input  wire logic [31:0] word,
    output logic             is_return_from_trap_instr,
    output logic             is_sar_reg,
    output logic             is_sar_imm,
    output logic             is_load_system_register_instr,
    output logic [4:0]       src_field,
    output logic [4:0]       dst_field
);
    logic [15:0] lo;
    logic [15:0] hi;
    assign lo         = word[15:0];
    assign hi         = word[31:16];
    assign src_field  = lo[4:0];
    assign dst_field  = lo[15:11];
    assign is_return_from_trap_instr    = (lo == erx_pkg::OP_RETURN_FROM_TRAP_INSTR_LO) && (hi == erx_pkg::OP_RETURN_FROM_TRAP_INSTR_HI);
    assign is_sar_reg = (lo[10:5] == erx_pkg::OP_FMT_IX) && (hi == erx_pkg::OP_SARR_HI);
    assign is_sar_imm = (lo[10:5] == erx_pkg::OP_SARI);
    assign is_load_system_register_instr    = (lo[10:5] == erx_pkg::OP_FMT_IX) && (hi == erx_pkg::OP_LOAD_SYSTEM_REGISTER_INSTR_HI);
endmodule : erx_decode

/* File: design/erx_exception_return_unit.sv */
// exception return and arithmetic right shift execution with apb registers
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ns
module erx_exception_return_unit (
    input  wire logic        MCLK,
    input  wire logic        RESET,
    // instruction from fetch
    input  wire logic        ID_VALID,
    input  wire logic [31:0] ID_WORD,
    input  wire logic [31:0] ID_PC,
    input  wire logic [31:0] ID_SRC,
    input  wire logic [31:0] ID_DST,
    output logic             ID_READY,
    // results
    output logic             WB_VALID,
    output logic [4:0]       WB_REG,
    output logic [31:0]      WB_DATA,
    output logic             FETCH_REDIRECT,
    output logic             FETCH_FLUSH,
    output logic [31:0]      FETCH_PC,
    output logic [31:0]      PSW_OUT,
    output logic             INT_BLOCK,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    erx_pkg::erx_state_t state;
    erx_pkg::erx_state_t next_state;
    logic        ctrl_en;
    logic [31:0] pc;
    logic [31:0] program_status_word;
    logic [31:0] int_saved_pc;
    logic [31:0] int_saved_status;
    logic [31:0] nmi_saved_pc;
    logic [31:0] nmi_saved_status;
    logic [31:0] op_word;
    logic [31:0] op_pc;
    logic [31:0] op_src;
    logic [31:0] op_dst;
    logic        is_return_from_trap_instr;
    logic        is_sar_reg;
    logic        is_sar_imm;
    logic        is_load_system_register_instr;
    logic [4:0]  src_field;
    logic [4:0]  dst_field;
    logic [4:0]  shift_count;
    logic [31:0] shift_res;
    logic        shift_carry;
    logic        exec;
    logic        use_nmi;
    logic [31:0] restore_pc;
    logic [31:0] restore_st;
    logic [31:0] next_pc_seq;
    logic        apb_wr;
    logic        load_system_register_instr_wr;
    logic [31:0] rd_mux;
    logic        rd_hit;

    // ------------------------------------------------------------
    // decode and shifter
    // ------------------------------------------------------------
    erx_decode u_decode (
        .word       (op_word),
        .is_return_from_trap_instr    (is_return_from_trap_instr),
        .is_sar_reg (is_sar_reg),
        .is_sar_imm (is_sar_imm),
        .is_load_system_register_instr    (is_load_system_register_instr),
        .src_field  (src_field),
        .dst_field  (dst_field)
    );

    // immediate count zero-extends; register count takes low five bits
    assign shift_count = is_sar_imm ? src_field : op_src[4:0];

    erx_sar_shift u_shift (
        .value  (op_dst),
        .count  (shift_count),
        .result (shift_res),
        .carry  (shift_carry)
    );

    // ------------------------------------------------------------
    // return source selection
    // ------------------------------------------------------------
    // trap flag wins regardless of nmi flag
    assign use_nmi    = !program_status_word[erx_pkg::PSW_TRAP] && program_status_word[erx_pkg::PSW_NMI];
    assign restore_pc = use_nmi ? nmi_saved_pc : int_saved_pc;
    assign restore_st = use_nmi ? nmi_saved_status : int_saved_status;
    assign next_pc_seq = op_pc + (is_sar_imm ? erx_pkg::LEN_SHORT : erx_pkg::LEN_LONG);
    assign exec    = (state == erx_pkg::ST_EXEC);
    assign load_system_register_instr_wr = exec && is_load_system_register_instr;
    assign apb_wr  = PSEL && PENABLE && PREADY && PWRITE;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            erx_pkg::ST_IDLE: begin
                if (ID_VALID && ID_READY) begin
                    next_state = erx_pkg::ST_DEC_LO;
                end
            end
            erx_pkg::ST_DEC_LO: next_state = erx_pkg::ST_DEC_HI;
            erx_pkg::ST_DEC_HI: next_state = erx_pkg::ST_EXEC;
            erx_pkg::ST_EXEC:   next_state = erx_pkg::ST_IDLE;
            default:            next_state = erx_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            state <= erx_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ready only when idle and enabled
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            ID_READY <= 1'b0;
        end else begin
            ID_READY <= ctrl_en && (next_state == erx_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            op_word <= 32'h0000_0000;
            op_pc   <= 32'h0000_0000;
            op_src  <= 32'h0000_0000;
            op_dst  <= 32'h0000_0000;
        end else if (state == erx_pkg::ST_IDLE && ID_VALID && ID_READY) begin
            op_word <= ID_WORD;
            op_pc   <= ID_PC;
            op_src  <= ID_SRC;
            op_dst  <= ID_DST;
        end
    end

    // ------------------------------------------------------------
    // interrupt acceptance gate
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            INT_BLOCK <= 1'b0;
        end else begin
            INT_BLOCK <= (next_state == erx_pkg::ST_DEC_HI) && is_load_system_register_instr;
        end
    end

    // ------------------------------------------------------------
    // program counter and fetch redirect
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            pc <= erx_pkg::PC_RESET;
        end else if (exec && is_return_from_trap_instr) begin
            pc <= restore_pc;
        end else if (exec) begin
            pc <= next_pc_seq;
        end else if (apb_wr && PADDR == erx_pkg::A_PC) begin
            pc <= PWDATA;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            FETCH_REDIRECT <= 1'b0;
            FETCH_FLUSH    <= 1'b0;
            FETCH_PC       <= erx_pkg::PC_RESET;
        end else begin
            FETCH_REDIRECT <= exec && is_return_from_trap_instr;
            FETCH_FLUSH    <= exec && is_return_from_trap_instr;
            FETCH_PC       <= (exec && is_return_from_trap_instr) ? restore_pc : FETCH_PC;
        end
    end

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            program_status_word <= erx_pkg::PSW_RESET;
        end else if (exec && is_return_from_trap_instr) begin
            program_status_word <= restore_st;
        end else if (exec && (is_sar_reg || is_sar_imm)) begin
            program_status_word[erx_pkg::PSW_CARRY] <= shift_carry;
            program_status_word[erx_pkg::PSW_WRAP]  <= 1'b0;
            program_status_word[erx_pkg::PSW_SIGN]  <= shift_res[31];
            program_status_word[erx_pkg::PSW_ZERO]  <= (shift_res == 32'h0000_0000);
        end else if (load_system_register_instr_wr && dst_field == erx_pkg::SR_PSW) begin
            program_status_word <= op_src;
        end else if (apb_wr && PADDR == erx_pkg::A_PSW) begin
            program_status_word <= PWDATA;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            PSW_OUT <= erx_pkg::PSW_RESET;
        end else begin
            PSW_OUT <= program_status_word;
        end
    end

    // ------------------------------------------------------------
    // save pairs
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            int_saved_pc <= 32'h0000_0000;
        end else if (load_system_register_instr_wr && dst_field == erx_pkg::SR_INT_PC) begin
            int_saved_pc <= op_src;
        end else if (apb_wr && PADDR == erx_pkg::A_INT_PC) begin
            int_saved_pc <= PWDATA;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            int_saved_status <= 32'h0000_0000;
        end else if (load_system_register_instr_wr && dst_field == erx_pkg::SR_INT_ST) begin
            int_saved_status <= op_src;
        end else if (apb_wr && PADDR == erx_pkg::A_INT_ST) begin
            int_saved_status <= PWDATA;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            nmi_saved_pc <= 32'h0000_0000;
        end else if (load_system_register_instr_wr && dst_field == erx_pkg::SR_NMI_PC) begin
            nmi_saved_pc <= op_src;
        end else if (apb_wr && PADDR == erx_pkg::A_NMI_PC) begin
            nmi_saved_pc <= PWDATA;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            nmi_saved_status <= 32'h0000_0000;
        end else if (load_system_register_instr_wr && dst_field == erx_pkg::SR_NMI_ST) begin
            nmi_saved_status <= op_src;
        end else if (apb_wr && PADDR == erx_pkg::A_NMI_ST) begin
            nmi_saved_status <= PWDATA;
        end
    end

    // ------------------------------------------------------------
    // shift result write-back
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            WB_VALID <= 1'b0;
            WB_REG   <= 5'h00;
            WB_DATA  <= 32'h0000_0000;
        end else begin
            WB_VALID <= exec && (is_sar_reg || is_sar_imm);
            WB_REG   <= dst_field;
            WB_DATA  <= shift_res;
        end
    end

    // ------------------------------------------------------------
    // apb slave: one wait-free access cycle, error on unmapped
    // ------------------------------------------------------------
    always_comb begin
        rd_hit = 1'b1;
        case (PADDR)
            erx_pkg::A_CTRL:   rd_mux = {31'h0000_0000, ctrl_en};
            erx_pkg::A_STATUS: rd_mux = {28'h000_0000, INT_BLOCK, exec, state != erx_pkg::ST_IDLE, ID_READY};
            erx_pkg::A_PC:     rd_mux = pc;
            erx_pkg::A_PSW:    rd_mux = program_status_word;
            erx_pkg::A_INT_PC: rd_mux = int_saved_pc;
            erx_pkg::A_INT_ST: rd_mux = int_saved_status;
            erx_pkg::A_NMI_PC: rd_mux = nmi_saved_pc;
            erx_pkg::A_NMI_ST: rd_mux = nmi_saved_status;
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !rd_hit;
            PRDATA  <= (PSEL && !PENABLE && !PWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            ctrl_en <= erx_pkg::CTRL_RESET;
        end else if (apb_wr && PADDR == erx_pkg::A_CTRL) begin
            ctrl_en <= PWDATA[0];
        end
    end
endmodule : erx_exception_return_unit

/* File: design/erx_pkg.sv */
// constants and types shared by the exception return unit
package erx_pkg;
    // ------------------------------------------------------------
    // status word field positions
    // ------------------------------------------------------------
    localparam int unsigned PSW_ZERO    = 0;
    localparam int unsigned PSW_SIGN    = 1;
    localparam int unsigned PSW_WRAP    = 2;
    localparam int unsigned PSW_CARRY   = 3;
    localparam int unsigned PSW_CLAMPED = 4;
    localparam int unsigned PSW_TRAP    = 5;
    localparam int unsigned PSW_NMI     = 6;
    localparam logic [31:0] PSW_RESET   = 32'h0000_0000;
    localparam logic [31:0] PC_RESET    = 32'h0000_0000;
    // ------------------------------------------------------------
    // opcode patterns (word[15:0] first halfword)
    // ------------------------------------------------------------
    localparam logic [15:0] OP_RETURN_FROM_TRAP_INSTR_LO  = 16'h07e0;
    localparam logic [15:0] OP_RETURN_FROM_TRAP_INSTR_HI  = 16'h0140;
    localparam logic [5:0]  OP_FMT_IX   = 6'h3f;
    localparam logic [15:0] OP_SARR_HI  = 16'h00a0;
    localparam logic [5:0]  OP_SARI     = 6'h15;
    localparam logic [15:0] OP_LOAD_SYSTEM_REGISTER_INSTR_HI  = 16'h0020;
    localparam logic [31:0] LEN_LONG    = 32'h0000_0004;
    localparam logic [31:0] LEN_SHORT   = 32'h0000_0002;
    // ------------------------------------------------------------
    // system register numbers for the load instruction
    // ------------------------------------------------------------
    localparam logic [4:0] SR_INT_PC    = 5'h00;
    localparam logic [4:0] SR_INT_ST    = 5'h01;
    localparam logic [4:0] SR_NMI_PC    = 5'h02;
    localparam logic [4:0] SR_NMI_ST    = 5'h03;
    localparam logic [4:0] SR_PSW       = 5'h05;
    // ------------------------------------------------------------
    // apb register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL       = 8'h00;
    localparam logic [7:0] A_STATUS     = 8'h04;
    localparam logic [7:0] A_PC         = 8'h08;
    localparam logic [7:0] A_PSW        = 8'h0c;
    localparam logic [7:0] A_INT_PC     = 8'h10;
    localparam logic [7:0] A_INT_ST     = 8'h14;
    localparam logic [7:0] A_NMI_PC     = 8'h18;
    localparam logic [7:0] A_NMI_ST     = 8'h1c;
    localparam logic       CTRL_RESET   = 1'b0;
    // ------------------------------------------------------------
    // sequencer states: decode takes two clocks (halves)
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DEC_LO,
        ST_DEC_HI,
        ST_EXEC
    } erx_state_t;
endpackage : erx_pkg

/* File: design/erx_sar_shift.sv */
// arithmetic right shifter with carry out
`timescale 1ns/1ns
module erx_sar_shift (
    input  wire logic [31:0] value,
    input  wire logic [4:0]  count,
    output logic [31:0]      result,
    output logic             carry
);
    logic [32:0] ext;
    logic [32:0] shifted;
    // extra low bit catches the last bit shifted out
    assign ext     = {value, 1'b0};
    assign shifted = 33'($signed(ext) >>> count);
    assign result  = shifted[32:1];
    assign carry   = (count == 5'h00) ? 1'b0 : shifted[0];
endmodule : erx_sar_shift

/* File: verification/erx_exception_return_unit_sva.sv */
// assertions on the ports of the exception return unit
`timescale 1ns/1ns
module erx_ret_chk (
    input wire logic        MCLK,
    input wire logic        RESET,
    input wire logic        ID_VALID,
    input wire logic [31:0] ID_WORD,
    input wire logic [31:0] ID_SRC,
    input wire logic [31:0] ID_DST,
    input wire logic        ID_READY,
    input wire logic        WB_VALID,
    input wire logic [4:0]  WB_REG,
    input wire logic [31:0] WB_DATA,
    input wire logic        FETCH_REDIRECT,
    input wire logic        FETCH_FLUSH,
    input wire logic [31:0] FETCH_PC,
    input wire logic [31:0] PSW_OUT,
    input wire logic        INT_BLOCK
);
    logic take, t_return_from_trap_instr, t_sarr, t_sari, t_load_system_register_instr;
    assign take   = ID_VALID && ID_READY;
    assign t_return_from_trap_instr = take && ID_WORD == {erx_pkg::OP_RETURN_FROM_TRAP_INSTR_HI, erx_pkg::OP_RETURN_FROM_TRAP_INSTR_LO};
    assign t_sarr = take && ID_WORD[10:5] == erx_pkg::OP_FMT_IX && ID_WORD[31:16] == erx_pkg::OP_SARR_HI;
    assign t_sari = take && ID_WORD[10:5] == erx_pkg::OP_SARI;
    assign t_load_system_register_instr = take && ID_WORD[10:5] == erx_pkg::OP_FMT_IX && ID_WORD[31:16] == erx_pkg::OP_LOAD_SYSTEM_REGISTER_INSTR_HI;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    AST_REDIR_FLUSH: assert property (FETCH_REDIRECT |-> FETCH_FLUSH)
        else $error("redirect without flush");
    AST_REDIR_CAUSE: assert property (FETCH_REDIRECT |-> $past(t_return_from_trap_instr, 4))
        else $error("redirect without a return");
    AST_RETURN_FROM_TRAP_INSTR_REDIR: assert property (t_return_from_trap_instr |-> ##4 FETCH_REDIRECT ##1 !FETCH_REDIRECT)
        else $error("return gave no single redirect pulse");
    AST_PC_HOLD: assert property (!FETCH_REDIRECT |-> $stable(FETCH_PC))
        else $error("fetch pc moved without redirect");
    AST_SAR_REG: assert property (t_sarr || t_sari |-> ##4 WB_VALID && WB_REG == $past(ID_WORD[15:11], 4))
        else $error("shift writeback missing or wrong register");
    AST_SAR_ZERO_CNT: assert property (t_sarr && ID_SRC[4:0] == 5'h00 |-> ##4 WB_DATA == $past(ID_DST, 4))
        else $error("zero count changed destination");
    AST_SARI_SIGN: assert property (t_sari |-> ##4 WB_DATA[31] == $past(ID_DST[31], 4))
        else $error("sign bit not kept");
    AST_SAR_FLAGS: assert property (t_sarr || t_sari |-> ##5 !PSW_OUT[erx_pkg::PSW_WRAP]
        && PSW_OUT[erx_pkg::PSW_ZERO] == ($past(WB_DATA) == 32'h0)
        && PSW_OUT[erx_pkg::PSW_SIGN] == $past(WB_DATA[31]))
        else $error("shift flags wrong");
    AST_LOAD_SYSTEM_REGISTER_INSTR_BLOCK: assert property (t_load_system_register_instr |-> ##1 !INT_BLOCK ##1 INT_BLOCK ##1 !INT_BLOCK)
        else $error("interrupt block not in second decode half");
    AST_BLOCK_CAUSE: assert property ($rose(INT_BLOCK) |-> $past(t_load_system_register_instr, 2))
        else $error("interrupt block without system load");
    COV_RETURN_FROM_TRAP_INSTR: cover property (t_return_from_trap_instr ##4 FETCH_REDIRECT);
    COV_SARI: cover property (t_sari ##4 WB_VALID);
    COV_LOAD_SYSTEM_REGISTER_INSTR: cover property (t_load_system_register_instr ##2 INT_BLOCK);
endmodule : erx_ret_chk

bind erx_exception_return_unit erx_ret_chk i_erx_ret_chk (
    .MCLK(MCLK), .RESET(RESET), .ID_VALID(ID_VALID), .ID_WORD(ID_WORD), .ID_SRC(ID_SRC), .ID_DST(ID_DST),
    .ID_READY(ID_READY), .WB_VALID(WB_VALID), .WB_REG(WB_REG), .WB_DATA(WB_DATA),
    .FETCH_REDIRECT(FETCH_REDIRECT), .FETCH_FLUSH(FETCH_FLUSH), .FETCH_PC(FETCH_PC),
    .PSW_OUT(PSW_OUT), .INT_BLOCK(INT_BLOCK)
);

/* File: verification/tb.sv */
// self-checking bench for the exception return unit
`timescale 1ns/1ns
module tb;
    logic        MCLK, RESET, ID_VALID, ID_READY, WB_VALID, FETCH_REDIRECT, FETCH_FLUSH, INT_BLOCK;
    logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, rd_err, wb_seen;
    logic [4:0]  WB_REG, wb_reg, n, dr;
    logic [7:0]  PADDR;
    logic [31:0] ID_WORD, ID_PC, ID_SRC, ID_DST, WB_DATA, FETCH_PC, PSW_OUT, PWDATA, PRDATA;
    logic [31:0] rd, wb_data, f_pc, v, d, pc_q, mpsw;
    logic [31:0] sv [4];
    logic [32:0] e;
    int          num_errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          ib_cnt, sel;

    erx_exception_return_unit i_erx_exception_return_unit (
        .MCLK(MCLK), .RESET(RESET), .ID_VALID(ID_VALID), .ID_WORD(ID_WORD), .ID_PC(ID_PC),
        .ID_SRC(ID_SRC), .ID_DST(ID_DST), .ID_READY(ID_READY), .WB_VALID(WB_VALID), .WB_REG(WB_REG),
        .WB_DATA(WB_DATA), .FETCH_REDIRECT(FETCH_REDIRECT), .FETCH_FLUSH(FETCH_FLUSH),
        .FETCH_PC(FETCH_PC), .PSW_OUT(PSW_OUT), .INT_BLOCK(INT_BLOCK), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR)
    );

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic stop_test();
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        // request stands until pready is seen at a rising edge
        do begin
            @(posedge MCLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        rd_err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    // offers one instruction, then watches the six cycles after its take
    task automatic instr(input logic [31:0] w, input logic [31:0] src, input logic [31:0] dst);
        @(posedge MCLK);
        pc_q = $urandom;
        ID_VALID <= 1'b1;
        ID_WORD <= w;
        ID_PC <= pc_q;
        ID_SRC <= src;
        ID_DST <= dst;
        do begin
            @(posedge MCLK);
        end while (ID_READY !== 1'b1);
        ID_VALID <= 1'b0;
        wb_seen = 1'b0;
        f_pc = 32'hxxxx_xxxx;
        ib_cnt = 0;
        repeat (6) begin
            @(negedge MCLK);
            ib_cnt += (INT_BLOCK === 1'b1);
            if (WB_VALID === 1'b1) begin
                wb_seen = 1'b1;
                wb_data = WB_DATA;
                wb_reg = WB_REG;
            end
            if (FETCH_REDIRECT === 1'b1 && FETCH_FLUSH === 1'b1)
                f_pc = FETCH_PC;
        end
    endtask : instr

    task automatic load_system_register_instr(input logic [4:0] sr, input logic [31:0] val);
        instr({erx_pkg::OP_LOAD_SYSTEM_REGISTER_INSTR_HI, sr, erx_pkg::OP_FMT_IX, 5'h00}, val, 32'h0);
        check(ib_cnt, 32'h1);
    endtask : load_system_register_instr

    function automatic logic [32:0] sar(input logic [31:0] x, input logic [4:0] c);
        logic [31:0] r;
        logic        co;
        r = x;
        co = 1'b0;
        repeat (c) begin
            co = r[0];
            r = {r[31], r[31:1]};
        end
        return {co, r};
    endfunction : sar

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {RESET, ID_VALID, PSEL, PENABLE, PWRITE} = 5'h10;
        {ID_WORD, ID_PC, ID_SRC, ID_DST, PWDATA} = '0;
        PADDR = 8'h00;
        void'($urandom(32'h6df0d04b));
        repeat (16) @(posedge MCLK);
        RESET <= 1'b0;
        apb(1'b0, erx_pkg::A_CTRL, 32'h0);
        check(rd, 32'(erx_pkg::CTRL_RESET));
        check(PSW_OUT, erx_pkg::PSW_RESET);
        apb(1'b1, erx_pkg::A_CTRL, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        check({rd_err, rd[30:0]}, 32'h8000_0000);
        // return with every trap/nmi flag combination
        for (int k = 0; k < 12; k++) begin
            for (int s = 0; s < 4; s++) begin
                sv[s] = $urandom;
                load_system_register_instr(5'(s), sv[s]);
            end
            v = $urandom;
            v[6:5] = 2'(k);
            load_system_register_instr(erx_pkg::SR_PSW, v);
            check(PSW_OUT & 32'h7f, v & 32'h7f);
            instr({erx_pkg::OP_RETURN_FROM_TRAP_INSTR_HI, erx_pkg::OP_RETURN_FROM_TRAP_INSTR_LO}, $urandom, $urandom);
            sel = (v[erx_pkg::PSW_TRAP] || !v[erx_pkg::PSW_NMI]) ? 0 : 2;
            check(f_pc, sv[sel]);
            check(PSW_OUT & 32'h7f, sv[sel + 1] & 32'h7f);
        end
        apb(1'b0, erx_pkg::A_NMI_ST, 32'h0);
        check(rd, sv[3]);
        // shifts, register and immediate forms, counts 0 and 31 first
        load_system_register_instr(erx_pkg::SR_PSW, 32'h10);
        mpsw = 32'h10;
        for (int k = 0; k < 40; k++) begin
            n = (k < 2) ? 5'(k * 31) : 5'($urandom);
            d = (k % 5 == 0) ? 32'h8000_0001 : $urandom;
            dr = 5'($urandom);
            v = $urandom;
            v[4:0] = k[0] ? ~n : n;
            if (k[0])
                instr({16'h0000, dr, erx_pkg::OP_SARI, n}, v, d);
            else
                instr({erx_pkg::OP_SARR_HI, dr, erx_pkg::OP_FMT_IX, 5'h03}, v, d);
            e = sar(d, n);
            mpsw[3:0] = {e[32], 1'b0, e[31], e[31:0] == 32'h0};
            check(32'(wb_seen), 32'h1);
            check(32'(wb_reg), 32'(dr));
            check(wb_data, e[31:0]);
            check(PSW_OUT & 32'h7f, mpsw);
        end
        apb(1'b0, erx_pkg::A_PC, 32'h0);
        check(rd, pc_q + 32'h2);
        // status reads idle and ready; every read-write register except ctrl echoes a write
        apb(1'b0, erx_pkg::A_STATUS, 32'h0);
        check(rd, 32'h1);
        for (int a = erx_pkg::A_PC; a <= erx_pkg::A_NMI_ST; a += 4) begin
            v = $urandom;
            apb(1'b1, 8'(a), v);
            apb(1'b0, 8'(a), 32'h0);
            check(rd, v);
        end
        stop_test();
    end
endmodule : tb
